// [common/pim_pkg.sv]
/*
  Shared constants and types for the per-port ingress rule-table access,
  mirroring and priority control registers.
  Assumes an 8-bit management register port with 16-bit addresses.
*/
package pim_pkg;

  localparam int NUM_PORTS = 5;
  localparam int NUM_CLASS = 5;
  localparam int SLOT_W    = 4;

  // Upper address digit for each register copy, in port slot order.
  localparam logic [3:0] PORT_NUMBER [NUM_PORTS] =
    '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};

  localparam logic [11:0] OFF_BYTE_EN_LOW = 12'h611;
  localparam logic [11:0] OFF_ACCESS_CTRL = 12'h612;
  localparam logic [11:0] OFF_MIRROR      = 12'h800;
  localparam logic [11:0] OFF_PRIORITY    = 12'h801;

  localparam int ACC_WRITE_DONE_BIT = 6;
  localparam int ACC_READ_DONE_BIT  = 5;
  localparam int ACC_DIR_BIT        = 4;

  localparam int MIR_RX_BIT      = 6;
  localparam int MIR_TX_BIT      = 5;
  localparam int MIR_SNIFFER_BIT = 1;

  localparam int PRI_HIGHEST_BIT = 7;
  localparam int PRI_OR_BIT      = 6;
  localparam int PRI_MAC_BIT     = 4;
  localparam int PRI_VLAN_BIT    = 3;
  localparam int PRI_DOT1P_BIT   = 2;
  localparam int PRI_DSCP_BIT    = 1;
  localparam int PRI_RULE_BIT    = 0;

  localparam logic [7:0] ACC_RESET = 8'h60;
  localparam logic [7:0] MIR_RESET = 8'h00;
  localparam logic [7:0] PRI_RESET = 8'h00;

  // Bits that software may store; all others are status or read zero.
  localparam logic [7:0] ACC_WMASK = 8'h1f;
  localparam logic [7:0] MIR_WMASK = 8'h62;
  localparam logic [7:0] PRI_WMASK = 8'hdf;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pim_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] prio;
  } pim_class_t;

  typedef struct packed {
    logic              valid;
    logic [2:0]        port;
    logic              write;
    logic [SLOT_W-1:0] slot;
    logic [7:0]        byteEn;
  } pim_table_req_t;

  typedef struct packed {
    logic rxSniff;
    logic txSniff;
    logic sniffer;
  } pim_mirror_t;

  typedef struct packed {
    logic                 highest;
    logic                 orMode;
    logic [NUM_CLASS-1:0] enable;
  } pim_prio_cfg_t;

endpackage

// [src/pim_prio_combine.sv]
/*
  Combines the classifier results of one port into one ingress priority.
  Assumes classifier index i is enabled by priority control bit i.
*/
`timescale 1ns/10ps
`default_nettype none

module pim_prio_combine (
  input  wire pim_pkg::pim_prio_cfg_t                   cfg,
  input  wire pim_pkg::pim_class_t [pim_pkg::NUM_CLASS-1:0] results,
  output pim_pkg::pim_class_t                           combined
);
  import pim_pkg::*;

  always_comb begin
    combined = '0;
    if (cfg.highest) begin
      for (int i = 0; i < NUM_CLASS; i++) begin
        if (cfg.enable[i] && results[i].valid) begin
          combined.valid = 1'b1;
          if (results[i].prio > combined.prio) begin
            combined.prio = results[i].prio;
          end
        end
      end
    end else if (cfg.orMode) begin
      for (int i = 0; i < NUM_CLASS; i++) begin
        if (cfg.enable[i] && results[i].valid) begin
          combined.valid = 1'b1;
          combined.prio  = combined.prio | results[i].prio;
        end
      end
    end else begin
      // Without a combining mode the lowest enabled index wins, so the
      // rule-table result overrides the packet-field classifiers.
      for (int i = NUM_CLASS - 1; i >= 0; i--) begin
        if (cfg.enable[i] && results[i].valid) begin
          combined = results[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [src/pim_port_regs.sv]
/*
  Per-port rule-table access control, mirroring and priority control
  registers for five switch ports, with the request path to the rule
  table and the mirroring and classification controls they steer.
  Assumes a synchronous register port that offers one access per cycle
  and a rule-table engine that reports each finished transfer once.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - One register copy per port, port digit addresses.
// - Access control holds direction bit and slot index.
// - Write-done flag reads one once write finishes.
// - Read-done flag reads one once read finishes.
// - Receive sniff marks received packets as monitored.
// - Transmit sniff marks transmitted packets as monitored.
// - Sniffer bit makes port transmit monitored packets.
// - Highest mode picks largest available classified priority.
// - OR mode combines available priorities bitwise.
// - MAC classification enabled by bit four.
// - VLAN classification enabled by bit three.
// - 802.1p classification enabled by bit two.
// - Diffserv classification enabled by bit one.
// - Rule-table priority enabled by bit zero.
// - Byte-enable low write launches transfer with enables.
module pim_port_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire pim_pkg::pim_reg_req_t  regReq,
  output logic [7:0]                  regRdata,
  output logic                        regRvalid,
  output pim_pkg::pim_table_req_t     tableReq,
  input  wire logic                   tableDone,
  input  wire logic [2:0]             tableDonePort,
  input  wire logic [pim_pkg::NUM_PORTS-1:0] pktRx,
  input  wire logic [pim_pkg::NUM_PORTS-1:0] pktTx,
  input  wire pim_pkg::pim_class_t [pim_pkg::NUM_PORTS-1:0]
                                      [pim_pkg::NUM_CLASS-1:0] classIn,
  output pim_pkg::pim_mirror_t [pim_pkg::NUM_PORTS-1:0] mirrorCfg,
  output logic [pim_pkg::NUM_PORTS-1:0] snifferMask,
  output logic [pim_pkg::NUM_PORTS-1:0] pktMonitored,
  output pim_pkg::pim_class_t [pim_pkg::NUM_PORTS-1:0] ingressPrio
);
  import pim_pkg::*;

  logic [7:0] accCtrl_q [NUM_PORTS];
  logic [7:0] accCtrl_d [NUM_PORTS];
  logic [7:0] mirror_q  [NUM_PORTS];
  logic [7:0] mirror_d  [NUM_PORTS];
  logic [7:0] prio_q    [NUM_PORTS];
  logic [7:0] prio_d    [NUM_PORTS];
  logic [NUM_PORTS-1:0] lastWrite_q;
  logic [NUM_PORTS-1:0] lastWrite_d;
  logic [NUM_PORTS-1:0] portHit;
  pim_table_req_t tableReq_d;
  logic [7:0]     rdata_d;

  pim_class_t [NUM_PORTS-1:0] combined;
  pim_class_t [NUM_PORTS-1:0] ingressPrio_d;
  logic [NUM_PORTS-1:0] pktMonitored_d;

  // Register port: decode, stores, launches and completion flags.
  always_comb begin
    tableReq_d  = '0;
    rdata_d     = 8'h00;
    lastWrite_d = lastWrite_q;
    for (int p = 0; p < NUM_PORTS; p++) begin
      accCtrl_d[p] = accCtrl_q[p];
      mirror_d[p]  = mirror_q[p];
      prio_d[p]    = prio_q[p];
      portHit[p]   = (regReq.addr[15:12] == PORT_NUMBER[p]);
      if (portHit[p] && regReq.write) begin
        unique case (regReq.addr[11:0])
          OFF_ACCESS_CTRL: begin
            accCtrl_d[p] = (accCtrl_q[p] & ~ACC_WMASK)
                         | (regReq.wdata & ACC_WMASK);
          end
          OFF_MIRROR: begin
            mirror_d[p] = regReq.wdata & MIR_WMASK;
          end
          OFF_PRIORITY: begin
            prio_d[p] = regReq.wdata & PRI_WMASK;
          end
          OFF_BYTE_EN_LOW: begin
            tableReq_d.valid  = 1'b1;
            tableReq_d.port   = 3'(p);
            tableReq_d.write  = accCtrl_q[p][ACC_DIR_BIT];
            tableReq_d.slot   = accCtrl_q[p][SLOT_W-1:0];
            tableReq_d.byteEn = regReq.wdata;
            lastWrite_d[p]    = accCtrl_q[p][ACC_DIR_BIT];
            if (accCtrl_q[p][ACC_DIR_BIT]) begin
              accCtrl_d[p][ACC_WRITE_DONE_BIT] = 1'b0;
            end else begin
              accCtrl_d[p][ACC_READ_DONE_BIT] = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // Completion is applied last so that it wins over a same-cycle clear.
      if (tableDone && tableDonePort == 3'(p)) begin
        if (lastWrite_q[p]) begin
          accCtrl_d[p][ACC_WRITE_DONE_BIT] = 1'b1;
        end else begin
          accCtrl_d[p][ACC_READ_DONE_BIT] = 1'b1;
        end
      end
      if (portHit[p] && regReq.read) begin
        unique case (regReq.addr[11:0])
          OFF_ACCESS_CTRL: rdata_d = accCtrl_q[p];
          OFF_MIRROR:      rdata_d = mirror_q[p];
          OFF_PRIORITY:    rdata_d = prio_q[p];
          default:         rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        accCtrl_q[p] <= ACC_RESET;
        mirror_q[p]  <= MIR_RESET;
        prio_q[p]    <= PRI_RESET;
      end
      lastWrite_q <= '0;
      tableReq    <= '0;
      regRdata    <= 8'h00;
      regRvalid   <= 1'b0;
    end else begin
      accCtrl_q   <= accCtrl_d;
      mirror_q    <= mirror_d;
      prio_q      <= prio_d;
      lastWrite_q <= lastWrite_d;
      tableReq    <= tableReq_d;
      regRdata    <= rdata_d;
      regRvalid   <= regReq.read;
    end
  end

  // Mirroring and priority classification per port.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pim_prio_cfg_t cfg;
    assign cfg.highest = prio_q[p][PRI_HIGHEST_BIT];
    assign cfg.orMode  = prio_q[p][PRI_OR_BIT];
    // Classifier index equals its enable bit position.
    assign cfg.enable  = {prio_q[p][PRI_MAC_BIT],
                          prio_q[p][PRI_VLAN_BIT],
                          prio_q[p][PRI_DOT1P_BIT],
                          prio_q[p][PRI_DSCP_BIT],
                          prio_q[p][PRI_RULE_BIT]};

    assign mirrorCfg[p].rxSniff = mirror_q[p][MIR_RX_BIT];
    assign mirrorCfg[p].txSniff = mirror_q[p][MIR_TX_BIT];
    assign mirrorCfg[p].sniffer = mirror_q[p][MIR_SNIFFER_BIT];
    assign snifferMask[p] = mirror_q[p][MIR_SNIFFER_BIT];

    pim_prio_combine u_combine (
      .cfg      (cfg),
      .results  (classIn[p]),
      .combined (combined[p])
    );
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pktMonitored_d[p] = (pktRx[p] && mirror_q[p][MIR_RX_BIT])
                       || (pktTx[p] && mirror_q[p][MIR_TX_BIT]);
      ingressPrio_d[p]  = combined[p];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pktMonitored <= '0;
      ingressPrio  <= '0;
    end else begin
      pktMonitored <= pktMonitored_d;
      ingressPrio  <= ingressPrio_d;
    end
  end

  // Checks, one set per port.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
    launch_req_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      regReq.write && regReq.addr == {PORT_NUMBER[p], OFF_BYTE_EN_LOW}
      |=> tableReq.valid && tableReq.port == 3'(p)
          && tableReq.byteEn == $past(regReq.wdata))
      else $error("byte-enable write did not launch a transfer");

    launch_clear_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      regReq.write && regReq.addr == {PORT_NUMBER[p], OFF_BYTE_EN_LOW}
      && accCtrl_q[p][ACC_DIR_BIT] && !tableDone
      |=> !accCtrl_q[p][ACC_WRITE_DONE_BIT])
      else $error("write launch left write-done set");

    write_done_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      tableDone && tableDonePort == 3'(p) && lastWrite_q[p]
      |=> accCtrl_q[p][ACC_WRITE_DONE_BIT])
      else $error("write-done not set on completion");

    read_pend_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      $fell(accCtrl_q[p][ACC_READ_DONE_BIT])
      |-> !accCtrl_q[p][ACC_READ_DONE_BIT]
          until (tableDone && tableDonePort == 3'(p)))
      else $error("read-done rose without completion");

    reset_val_a: assert property (
      @(posedge clk_sys)
      $past(reset) |-> accCtrl_q[p] == ACC_RESET
                    && mirror_q[p] == MIR_RESET && prio_q[p] == PRI_RESET)
      else $error("register not at reset value");

    rx_mon_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      pktRx[p] && mirrorCfg[p].rxSniff |=> pktMonitored[p])
      else $error("received packet not marked monitored");

    no_mon_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      !(pktTx[p] && mirrorCfg[p].txSniff)
      && !(pktRx[p] && mirrorCfg[p].rxSniff) |=> !pktMonitored[p])
      else $error("packet marked monitored without sniff");

    prio_read_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      regReq.read && !regReq.write
      && regReq.addr == {PORT_NUMBER[p], OFF_PRIORITY}
      |=> regRvalid && regRdata == $past(prio_q[p]))
      else $error("priority control read back wrong");

    no_class_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      prio_q[p][4:0] == 5'h00 |=> !ingressPrio[p].valid)
      else $error("priority valid with no classifier enabled");
  end

endmodule

`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench for the per-port register bank: reset values,
  storage, table launch and completion, mirroring and priority combining.
  Assumes the bench alone drives every input of the register block.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import pim_pkg::*;

  logic                                      clk_sys;
  logic                                      reset;
  pim_reg_req_t                              regReq;
  logic [7:0]                                regRdata;
  logic                                      regRvalid;
  pim_table_req_t                            tableReq;
  logic                                      tableDone;
  logic [2:0]                                tableDonePort;
  logic [NUM_PORTS-1:0]                      pktRx;
  logic [NUM_PORTS-1:0]                      pktTx;
  pim_class_t [NUM_PORTS-1:0][NUM_CLASS-1:0] classIn;
  pim_mirror_t [NUM_PORTS-1:0]               mirrorCfg;
  logic [NUM_PORTS-1:0]                      snifferMask;
  logic [NUM_PORTS-1:0]                      pktMonitored;
  pim_class_t [NUM_PORTS-1:0]                ingressPrio;
  int                                        fail_count;
  int                                        n_tests;
  int                                        cycles;
  logic [15:0]                               rnd;
  logic [7:0]                                mirQ [NUM_PORTS];
  logic [7:0]                                priQ [NUM_PORTS];
  logic [NUM_PORTS-1:0]                      expMon;
  logic [7:0]                                v;
  logic [7:0]                                be;
  logic [7:0]                                pend;
  logic [7:0]                                corner [6] =
    '{8'h9f, 8'h5f, 8'h1f, 8'hdf, 8'h01, 8'h10};

  pim_port_regs pim_port_regs_inst (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .regReq        (regReq),
    .regRdata      (regRdata),
    .regRvalid     (regRvalid),
    .tableReq      (tableReq),
    .tableDone     (tableDone),
    .tableDonePort (tableDonePort),
    .pktRx         (pktRx),
    .pktTx         (pktTx),
    .classIn       (classIn),
    .mirrorCfg     (mirrorCfg),
    .snifferMask   (snifferMask),
    .pktMonitored  (pktMonitored),
    .ingressPrio   (ingressPrio)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang in any handshake ends the run as a failure.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] ad(input int p, input logic [11:0] off);
    return {PORT_NUMBER[p], off};
  endfunction

  // Neither mode bit keeps the lowest enabled classifier index.
  function automatic logic [3:0] expPrio(input logic [7:0] cfg,
      input pim_class_t [NUM_CLASS-1:0] c);
    logic       ok;
    logic [2:0] p;
    ok = 1'b0;
    p = 3'h0;
    for (int i = 0; i < NUM_CLASS; i++) begin
      if (cfg[i] && c[i].valid) begin
        if (cfg[PRI_HIGHEST_BIT]) p = (c[i].prio > p) ? c[i].prio : p;
        else if (cfg[PRI_OR_BIT]) p = p | c[i].prio;
        else if (!ok) p = c[i].prio;
        ok = 1'b1;
      end
    end
    return {ok, ok ? p : 3'h0};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regReq = '{read: 1'b0, write: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    regReq = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    regReq = '{read: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    regReq = '0;
    check(17'({regRvalid, regRdata}), 17'({1'b1, e}));
  endtask

  task automatic finish(input int p);
    @(posedge clk_sys);
    #1;
    tableDone = 1'b1;
    tableDonePort = 3'(p);
    @(posedge clk_sys);
    #1;
    tableDone = 1'b0;
  endtask

  initial begin
    regReq = '0;
    tableDone = 1'b0;
    tableDonePort = 3'h0;
    pktRx = '0;
    pktTx = '0;
    classIn = '0;
    reset = 1'b1;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    rnd = 16'hc1eb;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(ad(p, OFF_ACCESS_CTRL), ACC_RESET);
      rd(ad(p, OFF_MIRROR), MIR_RESET);
      rd(ad(p, OFF_PRIORITY), PRI_RESET);
    end
    wr(16'h5612, 8'h1f);
    wr(16'h1613, 8'h1f);
    rd(16'h5612, 8'h00);
    rd(ad(0, OFF_ACCESS_CTRL), ACC_RESET);
    for (int k = 0; k < 20; k++) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        rnd = lfsr(rnd);
        wr(ad(p, OFF_ACCESS_CTRL), rnd[7:0]);
        v = (rnd[7:0] & ACC_WMASK) | ACC_RESET;
        rd(ad(p, OFF_ACCESS_CTRL), v);
        v = rnd[15:8] & MIR_WMASK;
        mirQ[p] = v;
        // Only the per-port bits live here; the switch-wide mirroring
        // control that software must also set sits outside this block.
        wr(ad(p, OFF_MIRROR), rnd[15:8]);
        rd(ad(p, OFF_MIRROR), v);
        check(17'(mirrorCfg[p]), 17'({v[6], v[5], v[1]}));
        check(17'(snifferMask[p]), 17'(v[1]));
      end
    end
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      pktRx = rnd[4:0];
      pktTx = rnd[9:5];
      for (int q = 0; q < NUM_PORTS; q++) begin
        expMon[q] = (pktRx[q] & mirQ[q][6]) | (pktTx[q] & mirQ[q][5]);
      end
      @(posedge clk_sys);
      #1;
      check(17'(pktMonitored), 17'(expMon));
    end
    pktRx = '0;
    pktTx = '0;
    for (int k = 0; k < 10; k++) begin
      int p;
      p = k % NUM_PORTS;
      rnd = lfsr(rnd);
      v = {3'b000, (k >= NUM_PORTS), rnd[3:0]};
      be = rnd[15:8];
      wr(ad(p, OFF_ACCESS_CTRL), v);
      wr(ad(p, OFF_BYTE_EN_LOW), be);
      check(17'(tableReq), {1'b1, 3'(p), v[4:0], be});
      pend = v | (v[4] ? 8'h20 : 8'h40);
      rd(ad(p, OFF_ACCESS_CTRL), pend);
      check(17'(tableReq.valid), 17'h0);
      finish((p + 1) % NUM_PORTS);
      rd(ad(p, OFF_ACCESS_CTRL), pend);
      finish(p);
      // Software polls the done flag here before it would touch rule data.
      rd(ad(p, OFF_ACCESS_CTRL), v | ACC_RESET);
      rd(ad(p, OFF_BYTE_EN_LOW), 8'h00);
    end
    for (int p = 0; p < NUM_PORTS; p++) priQ[p] = 8'h00;
    for (int k = 0; k < 200; k++) begin
      int p;
      rnd = lfsr(rnd);
      p = rnd % NUM_PORTS;
      // Settings with several bits go past the one-bit advice on purpose,
      // so that the combining modes meet several enabled classifiers.
      v = (k < 6) ? corner[k] : (rnd[15:8] & PRI_WMASK);
      priQ[p] = v;
      wr(ad(p, OFF_PRIORITY), v);
      for (int q = 0; q < NUM_PORTS; q++) begin
        for (int i = 0; i < NUM_CLASS; i++) begin
          rnd = lfsr(rnd);
          classIn[q][i] = rnd[3:0];
        end
      end
      @(posedge clk_sys);
      #1;
      for (int q = 0; q < NUM_PORTS; q++) begin
        check(17'(ingressPrio[q]),
              17'(expPrio(priQ[q], classIn[q])));
      end
    end
    results();
  end
endmodule

`default_nettype wire
